// File: pkg/smu_pkg.sv
// Package for the serial master unit: register map, field positions, states, carriers.
// Assumes a 25 MHz system clock and a byte-addressed plain register port.
package smu_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int CNT_W  = 16;
	localparam int PIN_N  = 32;
	localparam int PIN_W  = 5;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_TASK_START  = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_TASK_STOP   = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_EV_STOPPED  = 12'h104;
	localparam logic [ADDR_W-1:0] OFF_EV_RX_END   = 12'h110;
	localparam logic [ADDR_W-1:0] OFF_EV_END      = 12'h118;
	localparam logic [ADDR_W-1:0] OFF_EV_TX_END   = 12'h120;
	localparam logic [ADDR_W-1:0] OFF_EV_STARTED  = 12'h14C;
	localparam logic [ADDR_W-1:0] OFF_INTEN_SET   = 12'h304;
	localparam logic [ADDR_W-1:0] OFF_INTEN_CLR   = 12'h308;
	localparam logic [ADDR_W-1:0] OFF_ENABLE      = 12'h500;
	localparam logic [ADDR_W-1:0] OFF_PSEL_SCK    = 12'h508;
	localparam logic [ADDR_W-1:0] OFF_PSEL_MOSI   = 12'h50C;
	localparam logic [ADDR_W-1:0] OFF_PSEL_MISO   = 12'h510;
	localparam logic [ADDR_W-1:0] OFF_FREQ        = 12'h524;
	localparam logic [ADDR_W-1:0] OFF_RX_PTR      = 12'h534;
	localparam logic [ADDR_W-1:0] OFF_RX_CNT      = 12'h538;
	localparam logic [ADDR_W-1:0] OFF_RX_AMOUNT   = 12'h53C;
	localparam logic [ADDR_W-1:0] OFF_TX_PTR      = 12'h544;
	localparam logic [ADDR_W-1:0] OFF_TX_CNT      = 12'h548;
	localparam logic [ADDR_W-1:0] OFF_TX_AMOUNT   = 12'h54C;
	localparam logic [ADDR_W-1:0] OFF_CONFIG      = 12'h554;
	localparam logic [ADDR_W-1:0] OFF_OVR_CHAR    = 12'h5C0;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int CFG_ORDER = 0;
	localparam int CFG_PHASE = 1;
	localparam int CFG_POL   = 2;
	localparam int PSEL_DISC = 31;
	localparam int EV_STOPPED = 0;
	localparam int EV_RX_END  = 1;
	localparam int EV_END     = 2;
	localparam int EV_TX_END  = 3;
	localparam int EV_STARTED = 4;
	localparam int EV_N       = 5;
	localparam logic [31:0] RST_PSEL = 32'hFFFF_FFFF;
	localparam logic [7:0]  RST_FREQ = 8'h32;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 40;
	localparam int SCK_MIN_PERIOD_NS = 125;
	localparam int MIN_HALF_INT      =
		(SCK_MIN_PERIOD_NS + 2*CLK_PERIOD_NS - 1) / (2*CLK_PERIOD_NS);
	localparam logic [7:0] MIN_HALF  = 8'(MIN_HALF_INT);
	localparam logic [3:0] LAST_EDGE = 4'hF;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_NEXT  = 3'b001,
		ST_FETCH = 3'b010,
		ST_SHIFT = 3'b011,
		ST_STORE = 3'b100
	} smu_state_t;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
		logic [7:0]  data;
	} smu_mem_req_t;

endpackage : smu_pkg

// File: rtl/smu_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit may change at any time relative to clk.
`timescale 1ns/10ps
module smu_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : smu_sync

// File: rtl/smu_master.sv
// Serial master unit: full-duplex byte engine with reader and writer memory channels.
// Assumes memory acks arrive on clk; pins are asynchronous and pass a synchroniser.
`timescale 1ns/10ps

module smu_master
	import smu_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	output smu_mem_req_t           mem_rd,
	input  wire logic              mem_rd_ack,
	input  wire logic [7:0]        mem_rd_data,
	output smu_mem_req_t           mem_wr,
	input  wire logic              mem_wr_ack,
	output logic      [PIN_N-1:0]  pin_out,
	output logic      [PIN_N-1:0]  pin_oe,
	input  wire logic [PIN_N-1:0]  pin_in,
	output logic                   irq
);

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	logic [31:0]      psel_sck_r, psel_mosi_r, psel_miso_r, rx_ptr_r, tx_ptr_r;
	logic [CNT_W-1:0] rx_max_r, tx_max_r, rx_amt_r, tx_amt_r;
	logic [7:0]       freq_r, ovr_r;
	logic [2:0]       cfg_r;
	logic             en_r;
	logic [EV_N-1:0]  ev_r, inten_r;

	wire wr_start = reg_wr && reg_addr == OFF_TASK_START && reg_wdata[0];
	wire wr_stop  = reg_wr && reg_addr == OFF_TASK_STOP && reg_wdata[0];
	wire clr_hit  = reg_wr && !reg_wdata[0];
	wire [EV_N-1:0] ev_clr = {
		clr_hit && reg_addr == OFF_EV_STARTED,
		clr_hit && reg_addr == OFF_EV_TX_END,
		clr_hit && reg_addr == OFF_EV_END,
		clr_hit && reg_addr == OFF_EV_RX_END,
		clr_hit && reg_addr == OFF_EV_STOPPED};

	// Software side; the serial side never writes these
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{psel_sck_r, psel_mosi_r, psel_miso_r} <= {3{RST_PSEL}};
			{rx_ptr_r, tx_ptr_r, rx_max_r, tx_max_r} <= '0;
			{en_r, cfg_r, ovr_r, inten_r} <= '0;
			freq_r <= RST_FREQ;
		end else if (reg_wr) begin
			case (reg_addr)
				OFF_ENABLE:    en_r        <= reg_wdata[0];
				OFF_PSEL_SCK:  psel_sck_r  <= reg_wdata;
				OFF_PSEL_MOSI: psel_mosi_r <= reg_wdata;
				OFF_PSEL_MISO: psel_miso_r <= reg_wdata;
				OFF_FREQ:      freq_r      <= reg_wdata[7:0];
				OFF_RX_PTR:    rx_ptr_r    <= reg_wdata;
				OFF_RX_CNT:    rx_max_r    <= reg_wdata[CNT_W-1:0];
				OFF_TX_PTR:    tx_ptr_r    <= reg_wdata;
				OFF_TX_CNT:    tx_max_r    <= reg_wdata[CNT_W-1:0];
				OFF_CONFIG:    cfg_r       <= reg_wdata[2:0];
				OFF_OVR_CHAR:  ovr_r       <= reg_wdata[7:0];
				OFF_INTEN_SET: inten_r     <= inten_r | reg_wdata[EV_N-1:0];
				OFF_INTEN_CLR: inten_r     <= inten_r & ~reg_wdata[EV_N-1:0];
				default:       ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Working copies and state
	// ------------------------------------------------------------
	smu_state_t       st_r, st_nxt;
	logic [31:0]      tx_wptr_r, rx_wptr_r;
	logic [CNT_W-1:0] tx_wmax_r, rx_wmax_r, tx_cnt_r, rx_cnt_r;
	logic             txe_done_r, rxe_done_r, end_done_r, stop_pend_r;
	logic [7:0]       tx_sh_r, rx_sh_r, half_cnt_r;
	logic [3:0]       edge_r;
	logic             sck_r, mosi_r;
	logic [PIN_N-1:0] pin_sync;
	logic [7:0]       rx_sh_nxt;

	wire clk_pol  = cfg_r[CFG_POL];
	wire phase    = cfg_r[CFG_PHASE];
	wire lsb_1st  = cfg_r[CFG_ORDER];
	wire tx_hit   = tx_cnt_r == tx_wmax_r;
	wire rx_hit   = rx_cnt_r == rx_wmax_r;
	wire go       = wr_start && en_r && st_r == ST_IDLE;
	// Fill character once the transmit buffer is used up
	wire [7:0] load_byte = (st_r == ST_FETCH) ? mem_rd_data : ovr_r;

	// Rate register is clamped so a small value cannot exceed the pin limit
	wire [7:0] half_w   = (freq_r < MIN_HALF) ? MIN_HALF : freq_r;
	wire       half_end = half_cnt_r == half_w - 8'h01;
	wire       samp_edge  = half_end && (edge_r[0] == phase);
	wire       shift_edge = half_end && (edge_r[0] != phase);
	wire       byte_done  = st_r == ST_SHIFT && half_end && edge_r == LAST_EDGE;
	wire       loading    = st_nxt == ST_SHIFT && st_r != ST_SHIFT;

	// Stop or completion is only taken between bytes
	wire at_rest  = st_r == ST_NEXT && (stop_pend_r || (tx_hit && rx_hit));
	wire txe_set  = st_r == ST_NEXT && !txe_done_r && (tx_hit || stop_pend_r);
	wire rxe_set  = st_r == ST_NEXT && !rxe_done_r && (rx_hit || stop_pend_r);
	wire end_set  = st_r == ST_NEXT && !end_done_r && (txe_done_r || txe_set)
		&& (rxe_done_r || rxe_set);
	// A stop that meets the automatic finish still reports stopped
	wire stop_set = (st_r == ST_NEXT && stop_pend_r)
		|| (wr_stop && (st_r == ST_IDLE || at_rest));
	wire [EV_N-1:0] ev_set = {go, txe_set, end_set, rxe_set, stop_set};

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:  if (go) st_nxt = ST_NEXT;
			ST_NEXT: begin
				if (at_rest)
					st_nxt = ST_IDLE;
				else if (!tx_hit)
					st_nxt = ST_FETCH;
				else
					st_nxt = ST_SHIFT;
			end
			ST_FETCH: if (mem_rd_ack) st_nxt = ST_SHIFT;
			ST_SHIFT: begin
				if (byte_done)
					st_nxt = rx_hit ? ST_NEXT : ST_STORE;
			end
			ST_STORE: if (mem_wr_ack) st_nxt = ST_NEXT;
			default:  st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			st_r <= ST_IDLE;
		else
			st_r <= st_nxt;
	end

	// Double buffering: the live registers are free again once started is seen
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{tx_wptr_r, rx_wptr_r, tx_wmax_r, rx_wmax_r} <= '0;
		end else if (go) begin
			{tx_wptr_r, rx_wptr_r} <= {tx_ptr_r, rx_ptr_r};
			{tx_wmax_r, rx_wmax_r} <= {tx_max_r, rx_max_r};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{tx_cnt_r, rx_cnt_r} <= '0;
			{txe_done_r, rxe_done_r, end_done_r, stop_pend_r} <= '0;
		end else if (go) begin
			{tx_cnt_r, rx_cnt_r} <= '0;
			{txe_done_r, rxe_done_r, end_done_r, stop_pend_r} <= '0;
		end else begin
			if (st_r == ST_FETCH && mem_rd_ack)
				tx_cnt_r <= tx_cnt_r + 1'b1;
			if (st_r == ST_STORE && mem_wr_ack)
				rx_cnt_r <= rx_cnt_r + 1'b1;
			txe_done_r  <= txe_done_r | txe_set;
			rxe_done_r  <= rxe_done_r | rxe_set;
			end_done_r  <= end_done_r | end_set;
			stop_pend_r <= (stop_pend_r | (wr_stop && st_r != ST_IDLE)) && !at_rest;
		end
	end

	// Sticky events: a set in the same cycle as a clear wins
	always_ff @(posedge clk) begin
		if (!rst_b)
			ev_r <= '0;
		else
			ev_r <= (ev_r & ~ev_clr) | ev_set;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= |(ev_r & inten_r);
	end

	// ------------------------------------------------------------
	// Memory channels
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mem_rd <= '0;
		end else begin
			mem_rd.req  <= st_nxt == ST_FETCH && !(st_r == ST_FETCH && mem_rd_ack);
			mem_rd.addr <= tx_wptr_r + 32'(tx_cnt_r);
			mem_rd.data <= '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mem_wr <= '0;
		end else begin
			mem_wr.req <= st_nxt == ST_STORE && !(st_r == ST_STORE && mem_wr_ack);
			mem_wr.addr <= rx_wptr_r + 32'(rx_cnt_r);
			if (byte_done)
				mem_wr.data <= rx_sh_nxt;
		end
	end

	// ------------------------------------------------------------
	// Shift engine
	// ------------------------------------------------------------
	wire  miso_conn = en_r && !psel_miso_r[PSEL_DISC];
	wire  miso_bit  = miso_conn && pin_sync[psel_miso_r[PIN_W-1:0]];
	assign rx_sh_nxt = !samp_edge ? rx_sh_r :
		lsb_1st ? {miso_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], miso_bit};

	wire       out_bit  = lsb_1st ? tx_sh_r[0] : tx_sh_r[7];
	wire [7:0] tx_shift = lsb_1st ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};
	wire       load_bit = lsb_1st ? load_byte[0] : load_byte[7];
	wire [7:0] load_sh  = lsb_1st ? {1'b0, load_byte[7:1]} : {load_byte[6:0], 1'b0};

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{half_cnt_r, edge_r} <= '0;
		end else if (st_r != ST_SHIFT || half_end) begin
			half_cnt_r <= '0;
			edge_r     <= (st_r == ST_SHIFT) ? edge_r + 4'h1 : 4'h0;
		end else begin
			half_cnt_r <= half_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{tx_sh_r, rx_sh_r, mosi_r, sck_r} <= '0;
		end else if (loading) begin
			// Phase zero puts the first bit out before the first edge
			tx_sh_r <= phase ? load_byte : load_sh;
			mosi_r  <= phase ? mosi_r : load_bit;
			sck_r   <= clk_pol;
			rx_sh_r <= '0;
		end else if (st_r == ST_SHIFT) begin
			rx_sh_r <= rx_sh_nxt;
			if (half_end)
				sck_r <= !sck_r;
			if (shift_edge) begin
				mosi_r  <= out_bit;
				tx_sh_r <= tx_shift;
			end
		end else begin
			sck_r <= clk_pol;
			if (st_r == ST_IDLE)
				mosi_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pin routing, no chip select is driven here
	// ------------------------------------------------------------
	// Pin selects are read live; they are only safe to change while disabled
	wire [PIN_N-1:0] sck_sel  = (en_r && !psel_sck_r[PSEL_DISC])
		? (32'h0000_0001 << psel_sck_r[PIN_W-1:0]) : '0;
	wire [PIN_N-1:0] mosi_sel = (en_r && !psel_mosi_r[PSEL_DISC])
		? (32'h0000_0001 << psel_mosi_r[PIN_W-1:0]) : '0;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_out <= '0;
			pin_oe  <= '0;
		end else begin
			pin_out <= (sck_sel & {PIN_N{sck_r}}) | (mosi_sel & ~sck_sel & {PIN_N{mosi_r}});
			pin_oe  <= sck_sel | mosi_sel;
		end
	end

	smu_sync #(.W(PIN_N)) u_pin_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (pin_in),
		.q     (pin_sync)
	);

	// ------------------------------------------------------------
	// Amounts and read port
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b)
			{tx_amt_r, rx_amt_r} <= '0;
		else if (st_r == ST_NEXT)
			{tx_amt_r, rx_amt_r} <= {tx_cnt_r, rx_cnt_r};
	end

	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			OFF_EV_STOPPED: rd_mux = 32'(ev_r[EV_STOPPED]);
			OFF_EV_RX_END:  rd_mux = 32'(ev_r[EV_RX_END]);
			OFF_EV_END:     rd_mux = 32'(ev_r[EV_END]);
			OFF_EV_TX_END:  rd_mux = 32'(ev_r[EV_TX_END]);
			OFF_EV_STARTED: rd_mux = 32'(ev_r[EV_STARTED]);
			OFF_INTEN_SET:  rd_mux = 32'(inten_r);
			OFF_INTEN_CLR:  rd_mux = 32'(inten_r);
			OFF_ENABLE:     rd_mux = 32'(en_r);
			OFF_PSEL_SCK:   rd_mux = psel_sck_r;
			OFF_PSEL_MOSI:  rd_mux = psel_mosi_r;
			OFF_PSEL_MISO:  rd_mux = psel_miso_r;
			OFF_FREQ:       rd_mux = 32'(freq_r);
			OFF_RX_PTR:     rd_mux = rx_ptr_r;
			OFF_RX_CNT:     rd_mux = 32'(rx_max_r);
			OFF_RX_AMOUNT:  rd_mux = 32'(rx_amt_r);
			OFF_TX_PTR:     rd_mux = tx_ptr_r;
			OFF_TX_CNT:     rd_mux = 32'(tx_max_r);
			OFF_TX_AMOUNT:  rd_mux = 32'(tx_amt_r);
			OFF_CONFIG:     rd_mux = 32'(cfg_r);
			OFF_OVR_CHAR:   rd_mux = 32'(ovr_r);
			default:        rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_mux : '0;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_stop_seen;
		st_r == ST_NEXT && stop_pend_r;
	endsequence

	sequence s_rest_reached;
		st_r == ST_IDLE && ev_r[EV_STOPPED] && ev_r[EV_TX_END] && ev_r[EV_RX_END];
	endsequence

	chk_stop_rest: assert property (s_stop_seen ##1 !reg_wr |-> s_rest_reached)
		else $error("stop did not bring the master to rest with both end events");
	chk_auto_stop: assert property (st_r == ST_NEXT && tx_hit && rx_hit |=> st_r == ST_IDLE)
		else $error("master kept running after both counts were done");
	chk_end_both: assert property ($rose(ev_r[EV_END]) |-> txe_done_r && rxe_done_r)
		else $error("combined end raised before both ends");
	chk_start_latch: assert property (go |=> st_r == ST_NEXT && ev_r[EV_STARTED]
		&& tx_wmax_r == $past(tx_max_r) && rx_wmax_r == $past(rx_max_r))
		else $error("start did not latch counts or raise started");
	chk_byte_length: assert property (st_r == ST_SHIFT && st_nxt != ST_SHIFT
		|-> edge_r == LAST_EDGE && half_end)
		else $error("byte left the shifter before sixteen clock edges");
	chk_discard_extra: assert property ($rose(mem_wr.req) |-> rx_cnt_r < rx_wmax_r)
		else $error("received byte written beyond the receive count");
	chk_fill_char: assert property (st_r == ST_NEXT && st_nxt == ST_SHIFT
		|-> tx_hit && load_byte == ovr_r)
		else $error("over-read byte is not the fill character");
	// The idle clock follows a polarity change one cycle later
	chk_idle_levels: assert property ((st_r == ST_IDLE)[*2]
		|-> sck_r == $past(clk_pol) && !mosi_r)
		else $error("idle clock or data level wrong");
	chk_pin_route: assert property (en_r && !psel_sck_r[PSEL_DISC] && $stable(psel_sck_r)
		|=> pin_out[psel_sck_r[PIN_W-1:0]] == $past(sck_r))
		else $error("serial clock not on its selected pin");
	chk_clock_rate: assert property ($rose(sck_r) && st_r == ST_SHIFT
		|-> $past(sck_r, 1) == 1'b0 && $past(sck_r, 2) == 1'b0)
		else $error("serial half period shorter than two cycles");

endmodule : smu_master

// File: test/smu_slave_model.sv
// Behavioural serial slave on the far side of the serial master unit.
// Assumes the bench fills tx_q and sets the mode inputs before raising arm.
`timescale 1ns/10ps
module smu_slave_model (
	input  wire logic sck,
	input  wire logic data_in,
	input  wire logic cpol,
	input  wire logic cpha,
	input  wire logic lsb,
	input  wire logic arm,
	output logic      data_out
);
	// ------------------------------------------------------------
	// Shift state
	// ------------------------------------------------------------
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	logic [7:0] sh_out;
	logic [7:0] sh_in;
	int         n_out;
	int         n_in;

	initial begin
		data_out = 1'b0;
	end

	// Reload from the queue when a byte is used up; an empty queue sends all ones
	task automatic shift_out;
		if (n_out == 8) begin
			sh_out = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hFF;
			n_out  = 0;
		end
		data_out = lsb ? sh_out[n_out] : sh_out[7 - n_out];
		n_out++;
	endtask : shift_out

	always @(posedge arm) begin
		n_out = 8;
		n_in  = 0;
		if (!cpha)
			shift_out();
	end

	// A released line must not keep its last level
	always @(negedge arm) begin
		data_out = ~data_out;
	end

	// Leading edge leaves the idle level; phase picks which edge shifts
	always @(sck) begin
		if (arm) begin
			if ((sck !== cpol) == cpha) begin
				shift_out();
			end else begin
				sh_in = lsb ? {data_in, sh_in[7:1]} : {sh_in[6:0], data_in};
				n_in++;
				if (n_in == 8) begin
					rx_q.push_back(sh_in);
					n_in = 0;
				end
			end
		end
	end
endmodule : smu_slave_model

// File: test/spi_master_dma_engine_bench.sv
// Self-checking bench for the serial master unit with memory and slave models.
// Assumes a 25 MHz clock and the slave on pins 3, 5 and 7.
`timescale 1ns/10ps
module spi_master_dma_engine_bench import smu_pkg::*;;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int SCK_PIN = 3;
	localparam int MO_PIN  = 5;
	localparam int MI_PIN  = 7;
	logic              clk, rst_b, reg_wr, reg_rd, mem_rd_ack, mem_wr_ack;
	logic              miso, s_cpol, s_cpha, s_lsb, s_arm, irq;
	logic [ADDR_W-1:0] reg_addr;
	logic [31:0]       reg_wdata, reg_rdata, rd_val;
	logic [7:0]        mem_rd_data;
	logic [7:0]        tx_mem[256];
	logic [7:0]        wr_q[$];
	smu_mem_req_t      mem_rd, mem_wr;
	logic [PIN_N-1:0]  pin_out, pin_oe, pin_in;
	int                n_mismatch, checks;
	logic [ADDR_W-1:0] ev_off[5] = '{OFF_EV_STOPPED, OFF_EV_RX_END, OFF_EV_END, OFF_EV_TX_END,
		OFF_EV_STARTED};

	assign pin_in = PIN_N'(miso) << MI_PIN;

	smu_master i_smu_master (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mem_rd(mem_rd), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .mem_wr(mem_wr),
		.mem_wr_ack(mem_wr_ack), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .irq(irq));

	smu_slave_model i_smu_slave_model (.sck(pin_out[SCK_PIN]), .data_in(pin_out[MO_PIN]),
		.cpol(s_cpol), .cpha(s_cpha), .lsb(s_lsb), .arm(s_arm), .data_out(miso));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Memory answers one cycle after each request, never two acks in a row
	always @(posedge clk) begin
		mem_rd_ack  <= mem_rd.req && !mem_rd_ack;
		mem_rd_data <= tx_mem[mem_rd.addr[7:0]];
		mem_wr_ack  <= mem_wr.req && !mem_wr_ack;
		if (mem_wr.req && mem_wr_ack)
			wr_q.push_back(mem_wr.data);
	end

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd

	// Bounded poll; a flag that never rises leaves rd_val low for the caller
	task automatic wait_ev(input logic [ADDR_W-1:0] a);
		rd_val = 32'h0000_0000;
		for (int i = 0; i < 3000 && rd_val[0] !== 1'b1; i++)
			rd(a);
	endtask : wait_ev

	task automatic clear_events;
		for (int i = 0; i < 5; i++)
			wr(ev_off[i], 32'h0000_0000);
	endtask : clear_events

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		rd(OFF_PSEL_SCK);
		check(rd_val, RST_PSEL);
		rd(OFF_FREQ);
		check(rd_val, {24'h00_0000, RST_FREQ});
		rd(12'h7FC);
		check(rd_val, 32'h0000_0000);
		check(pin_oe, 32'h0000_0000);
		wr(OFF_PSEL_SCK, 32'(SCK_PIN));
		wr(OFF_PSEL_MOSI, 32'(MO_PIN));
		wr(OFF_PSEL_MISO, 32'(MI_PIN));
		wr(OFF_FREQ, 32'h0000_0004);
		wr(OFF_INTEN_SET, 32'h0000_0004);
		wr(OFF_ENABLE, 32'h0000_0001);
	endtask : test_reset

	task automatic test_xfer(input logic [1:0] mode, input int ntx, input int nrx);
		logic lsb;
		int   n;
		lsb = mode[1] ^ mode[0];
		n   = (ntx > nrx) ? ntx : nrx;
		wr(OFF_CONFIG, {29'h0000_0000, mode[1], mode[0], lsb});
		clear_events();
		wr(OFF_TX_PTR, 32'h0000_0000);
		wr(OFF_TX_CNT, 32'(ntx));
		wr(OFF_RX_PTR, 32'h0000_0080);
		wr(OFF_RX_CNT, 32'(nrx));
		wr(OFF_OVR_CHAR, 32'h0000_00E7);
		check({pin_oe[SCK_PIN], pin_oe[MO_PIN], pin_out[SCK_PIN], pin_out[MO_PIN]},
			{2'b11, mode[1], 1'b0});
		wr_q.delete();
		i_smu_slave_model.rx_q.delete();
		// Bytes the slave preloaded last time must not leak into this transfer
		i_smu_slave_model.tx_q.delete();
		for (int i = 0; i < 8; i++) begin
			tx_mem[i] = 8'hA0 + 8'(i) + 8'(mode) * 8'h10;
			i_smu_slave_model.tx_q.push_back(8'h30 + 8'(i) + 8'(mode) * 8'h10);
		end
		s_cpol <= mode[1];
		s_cpha <= mode[0];
		s_lsb  <= lsb;
		s_arm  <= 1'b1;
		wr(OFF_TASK_START, 32'h0000_0001);
		wait_ev(OFF_EV_STARTED);
		check(rd_val, 32'h0000_0001);
		// Shadow reload while running must not disturb this transfer
		wr(OFF_TX_CNT, 32'h0000_0009);
		wr(OFF_RX_CNT, 32'h0000_0009);
		wait_ev(OFF_EV_END);
		check(rd_val, 32'h0000_0001);
		check(32'(irq), 32'h0000_0001);
		rd(OFF_EV_TX_END);
		check(rd_val, 32'h0000_0001);
		rd(OFF_EV_RX_END);
		check(rd_val, 32'h0000_0001);
		rd(OFF_EV_STOPPED);
		check(rd_val, 32'h0000_0000);
		rd(OFF_TX_AMOUNT);
		check(rd_val, 32'(ntx));
		rd(OFF_RX_AMOUNT);
		check(rd_val, 32'(nrx));
		check(32'(i_smu_slave_model.rx_q.size()), 32'(n));
		for (int i = 0; i < n; i++)
			check(i_smu_slave_model.rx_q[i], (i < ntx) ? tx_mem[i] : 8'hE7);
		check(32'(wr_q.size()), 32'(nrx));
		for (int i = 0; i < nrx; i++)
			check(wr_q[i], 8'h30 + 8'(i) + 8'(mode) * 8'h10);
		s_arm <= 1'b0;
	endtask : test_xfer

	task automatic test_stop;
		clear_events();
		check(32'(irq), 32'h0000_0000);
		wr(OFF_TX_CNT, 32'h0000_0004);
		wr(OFF_RX_CNT, 32'h0000_0004);
		wr_q.delete();
		s_arm <= 1'b1;
		wr(OFF_TASK_START, 32'h0000_0001);
		repeat (60) @(posedge clk);
		wr(OFF_TASK_STOP, 32'h0000_0001);
		wait_ev(OFF_EV_STOPPED);
		check(rd_val, 32'h0000_0001);
		rd(OFF_EV_TX_END);
		check(rd_val, 32'h0000_0001);
		rd(OFF_EV_RX_END);
		check(rd_val, 32'h0000_0001);
		check(32'(wr_q.size() < 4), 32'h0000_0001);
		s_arm <= 1'b0;
		wr(OFF_ENABLE, 32'h0000_0000);
		repeat (3) @(posedge clk);
		check(pin_oe, 32'h0000_0000);
	endtask : test_stop

	task automatic finish_test;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// Whole plan is about a thousand cycles; this is far beyond it
	initial begin
		#2_400_000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		{rst_b, reg_wr, reg_rd, s_cpol, s_cpha, s_lsb, s_arm} = 7'h00;
		{mem_rd_ack, mem_wr_ack, mem_rd_data} = 10'h000;
		reg_addr  = 12'h000;
		reg_wdata = 32'h0000_0000;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		test_reset();
		test_xfer(2'h0, 2, 3);
		test_xfer(2'h1, 3, 1);
		test_xfer(2'h2, 1, 1);
		test_xfer(2'h3, 2, 2);
		test_stop();
		finish_test();
	end
endmodule : spi_master_dma_engine_bench
